// file: design/tmr_prescale.sv
// Purpose: timer clock enable from the system clock
// Assumes: select is a same-domain register
// Notes: free running divider, tick on all-ones of the mask
`timescale 1ns/1ns
`default_nettype none
module tmr_prescale (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // Control
  input wire logic [2:0] SEL,
  // Timer clock enable
  output logic TICK
);
  import tmr_wave_pkg::*;
  logic [PSW-1:0] div_q;
  logic [PSW-1:0] mask;
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end
  always_comb begin
    mask = '0;
    unique case (SEL)
      CS_8: mask = DIV8_M;
      CS_64: mask = DIV64_M;
      CS_256: mask = DIV256_M;
      CS_1024: mask = DIV1024_M;
      default: mask = '0;
    endcase
  end
  assign TICK = (SEL == CS_1) ||
                ((SEL inside {CS_8, CS_64, CS_256, CS_1024}) &&
                 ((div_q & mask) == mask));
endmodule
`default_nettype wire

// file: design/tmr_wave.sv
// Purpose: 8-bit timer with clear-on-match, fast and phase-correct PWM
// Assumes: plain register port, read data one cycle after read strobe
// Notes: pin direction logic stays outside; outputs carry the level
`timescale 1ns/1ns
`default_nettype none
module tmr_wave (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // Register port
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  // Waveform outputs and override enables
  output logic WAVE_OUT_A,
  output logic WAVE_OUT_B,
  output logic OVR_A,
  output logic OVR_B
);
  import tmr_wave_pkg::*;
  typedef enum logic [1:0] {
    DIR_UP = 2'b01,
    DIR_DOWN = 2'b10
  } dir_t;
  logic [15:0] ctrl_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cmpa_q;
  logic [CW-1:0] cmpb_q;
  logic [CW-1:0] bufa_q;
  logic [CW-1:0] bufb_q;
  logic ovf_q;
  logic cfa_q;
  logic cfb_q;
  logic wa_q;
  logic wb_q;
  logic blk_q;
  logic pma_q;
  logic pmb_q;
  dir_t dir_q;
  logic [15:0] rdata_q;
  logic tick;
  logic [2:0] wgm;
  logic [1:0] coma;
  logic [1:0] comb;
  logic is_ctc;
  logic is_fast;
  logic is_pc;
  logic is_pwm;
  logic [CW-1:0] top;
  logic at_top;
  logic match_a;
  logic match_b;
  logic wr_cnt;
  logic load_buf;
  logic wr_flags;

  assign wgm = ctrl_q[F_WGM_LO +: 3];
  assign coma = ctrl_q[F_COMA_LO +: 2];
  assign comb = ctrl_q[F_COMB_LO +: 2];
  assign is_ctc = (wgm == WM_CTC);
  assign is_fast = (wgm == WM_FAST_FF) || (wgm == WM_FAST_A);
  assign is_pc = (wgm == WM_PCPWM_FF) || (wgm == WM_PCPWM_A);
  assign is_pwm = is_fast || is_pc;
  assign top = (wgm == WM_FAST_A || wgm == WM_PCPWM_A ||
                is_ctc) ? cmpa_q : MAXV;
  assign at_top = (cnt_q == top);
  assign match_a = (cnt_q == cmpa_q) && !blk_q;
  assign match_b = (cnt_q == cmpb_q) && !blk_q;
  assign wr_cnt = WR && (ADDR == A_CNT);
  assign wr_flags = WR && (ADDR == A_FLAGS);
  assign load_buf = tick && ((is_fast && at_top) ||
                    (is_pc && at_top && dir_q == DIR_UP));
  assign OVR_A = (coma != COM_OFF);
  assign OVR_B = (comb != COM_OFF);
  assign WAVE_OUT_A = wa_q;
  assign WAVE_OUT_B = wb_q;

  tmr_prescale u_pre (
    .CLK_SYS(CLK_SYS),
    .RST(RST),
    .SEL(ctrl_q[F_CS_LO +: 3]),
    .TICK(tick)
  );

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ctrl_q <= '0;
    end else if (WR && ADDR == A_CTRL) begin
      ctrl_q <= WDATA;
    end
  end

  // direct write outside PWM; buffered in PWM
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      bufa_q <= '0;
      bufb_q <= '0;
      cmpa_q <= '0;
      cmpb_q <= '0;
    end else begin
      if (WR && ADDR == A_CMPA) begin
        bufa_q <= WDATA[CW-1:0];
      end
      if (WR && ADDR == A_CMPB) begin
        bufb_q <= WDATA[CW-1:0];
      end
      if (!is_pwm) begin
        if (WR && ADDR == A_CMPA) begin
          cmpa_q <= WDATA[CW-1:0];
        end
        if (WR && ADDR == A_CMPB) begin
          cmpb_q <= WDATA[CW-1:0];
        end
      end else if (load_buf) begin
        cmpa_q <= bufa_q;
        cmpb_q <= bufb_q;
      end
    end
  end

  // block set by counter write, cleared on next tick
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      blk_q <= 1'b0;
    end else if (wr_cnt) begin
      blk_q <= 1'b1;
    end else if (tick) begin
      blk_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      cnt_q <= '0;
      dir_q <= DIR_UP;
    end else if (wr_cnt) begin
      cnt_q <= WDATA[CW-1:0];
    end else if (tick) begin
      if (is_pc) begin
        // dual slope, TOP not held, next tick counts down
        unique case (dir_q)
          DIR_UP: begin
            if (at_top) begin
              dir_q <= DIR_DOWN;
              cnt_q <= cnt_q - 1'b1;
            end else begin
              cnt_q <= cnt_q + 1'b1;
            end
          end
          DIR_DOWN: begin
            if (cnt_q == BOTTOM) begin
              dir_q <= DIR_UP;
              cnt_q <= cnt_q + 1'b1;
            end else begin
              cnt_q <= cnt_q - 1'b1;
            end
          end
        endcase
      end else begin
        dir_q <= DIR_UP;
        // clear on match; clear after TOP
        // a missed match wraps through MAXV naturally
        if ((is_ctc && match_a) || (is_fast && at_top)) begin
          cnt_q <= BOTTOM;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end

  // Match pending, flag one tick later
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      pma_q <= 1'b0;
      pmb_q <= 1'b0;
    end else if (wr_cnt) begin
      pma_q <= 1'b0;
      pmb_q <= 1'b0;
    end else if (tick) begin
      pma_q <= match_a;
      pmb_q <= match_b;
    end
  end

  // flags set a tick after match, set wins over clear
  // compare A flag at TOP in clear-on-match
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      cfa_q <= 1'b0;
      cfb_q <= 1'b0;
    end else begin
      if (tick && pma_q) begin
        cfa_q <= 1'b1;
      end else if (wr_flags && WDATA[F_CFA]) begin
        cfa_q <= 1'b0;
      end
      if (tick && pmb_q) begin
        cfb_q <= 1'b1;
      end else if (wr_flags && WDATA[F_CFB]) begin
        cfb_q <= 1'b0;
      end
    end
  end

  logic ovf_set;
  // MAX to 0x00 step, cleared or wrapped
  // fast PWM at TOP; phase-correct at BOTTOM
  assign ovf_set = tick && ((is_ctc && cnt_q == MAXV) ||
                   (is_fast && at_top) ||
                   (is_pc && dir_q == DIR_DOWN && cnt_q == BOTTOM) ||
                   (!is_pwm && !is_ctc && cnt_q == MAXV));

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ovf_q <= 1'b0;
    end else if (ovf_set) begin
      ovf_q <= 1'b1;
    end else if (wr_flags && WDATA[F_OVF]) begin
      ovf_q <= 1'b0;
    end
  end

  // Waveform action for one channel
  function automatic logic wave_next(input logic cur, input logic [1:0] com,
      input logic m, input logic tog_ok, input logic at_bot,
      input logic up, input logic clear_on_match_mode, input logic fast,
      input logic pc);
    logic r;
    r = cur;
    if (com == COM_OFF) begin
      r = cur;
    end else if (com == COM_TOG) begin
      // clear-on-match toggle; PWM toggle needs msb
      if (m && (clear_on_match_mode || (tog_ok && (fast || pc)) || !(fast || pc))) begin
        r = !cur;
      end
    end else if (clear_on_match_mode || !(fast || pc)) begin
      if (m) begin
        r = (com == COM_SET);
      end
    end else if (fast) begin
      // set at BOTTOM, clear at match (mode 2)
      // match at BOTTOM wins, one-tick spike
      // match at MAX never releases BOTTOM level
      if (m) begin
        r = (com == COM_SET);
      end else if (at_bot) begin
        r = (com == COM_CLR);
      end
    end else if (m) begin
      // up match clears, down match sets (mode 2)
      r = up ? (com == COM_SET) : (com == COM_CLR);
    end
    return r;
  endfunction

  logic bot_next;
  logic hit_a;
  logic hit_b;
  assign bot_next = is_fast && at_top;
  // match at TOP ignored, BOTTOM action only
  assign hit_a = match_a && !(is_fast && at_top && coma[1]);
  assign hit_b = match_b && !(is_fast && at_top && cmpb_q == top &&
                 comb[1]);

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      wa_q <= 1'b0;
    end else if (tick) begin
      wa_q <= wave_next(wa_q, coma, hit_a, wgm[2], bot_next,
              dir_q == DIR_UP, is_ctc, is_fast, is_pc);
    end
  end

  // no toggle option on channel B in PWM modes
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      wb_q <= 1'b0;
    end else if (tick) begin
      wb_q <= wave_next(wb_q, comb, hit_b, 1'b0, bot_next,
              dir_q == DIR_UP, is_ctc, is_fast, is_pc);
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      rdata_q <= '0;
    end else if (RD) begin
      unique case (ADDR)
        A_CTRL: rdata_q <= ctrl_q;
        A_CNT: rdata_q <= {8'h00, cnt_q};
        A_CMPA: rdata_q <= {8'h00, is_pwm ? bufa_q : cmpa_q};
        A_CMPB: rdata_q <= {8'h00, is_pwm ? bufb_q : cmpb_q};
        A_FLAGS: rdata_q <= {13'h0000, cfb_q, cfa_q, ovf_q};
        default: rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end
  assign RDATA = rdata_q;
endmodule
`default_nettype wire

// file: design/tmr_wave_pkg.sv
// Purpose: constants shared by the waveform timer
// Assumes: 8-bit counter, 10 MHz system clock
// Notes: offsets are word addresses on the plain register port
package tmr_wave_pkg;
  localparam int CW = 8;
  localparam logic [7:0] BOTTOM = 8'h00;
  localparam logic [7:0] MAXV = 8'hFF;
  // Register addresses
  localparam logic [3:0] A_CTRL = 4'h0;
  localparam logic [3:0] A_CNT = 4'h1;
  localparam logic [3:0] A_CMPA = 4'h2;
  localparam logic [3:0] A_CMPB = 4'h3;
  localparam logic [3:0] A_FLAGS = 4'h4;
  // Control field positions
  localparam int F_WGM_LO = 0;
  localparam int F_CS_LO = 3;
  localparam int F_COMB_LO = 6;
  localparam int F_COMA_LO = 8;
  // Flag bit positions
  localparam int F_OVF = 0;
  localparam int F_CFA = 1;
  localparam int F_CFB = 2;
  // Waveform modes
  localparam logic [2:0] WM_PCPWM_FF = 3'd1;
  localparam logic [2:0] WM_CTC = 3'd2;
  localparam logic [2:0] WM_FAST_FF = 3'd3;
  localparam logic [2:0] WM_PCPWM_A = 3'd5;
  localparam logic [2:0] WM_FAST_A = 3'd7;
  // Output modes
  localparam logic [1:0] COM_OFF = 2'd0;
  localparam logic [1:0] COM_TOG = 2'd1;
  localparam logic [1:0] COM_CLR = 2'd2;
  localparam logic [1:0] COM_SET = 2'd3;
  // Prescale selects and divide masks
  localparam logic [2:0] CS_STOP = 3'd0;
  localparam logic [2:0] CS_1 = 3'd1;
  localparam logic [2:0] CS_8 = 3'd2;
  localparam logic [2:0] CS_64 = 3'd3;
  localparam logic [2:0] CS_256 = 3'd4;
  localparam logic [2:0] CS_1024 = 3'd5;
  localparam int PSW = 10;
  localparam logic [9:0] DIV8_M = 10'h007;
  localparam logic [9:0] DIV64_M = 10'h03F;
  localparam logic [9:0] DIV256_M = 10'h0FF;
  localparam logic [9:0] DIV1024_M = 10'h3FF;
endpackage

// file: test/port_pin_model.sv
// Purpose: port pin model for one waveform output
// Assumes: direction comes from the surrounding port, override from the timer
// Notes: an input pin shows a changing pattern, not a held level
`timescale 1ns/1ns
`default_nettype none
module port_pin_model (
  // Clock
  input wire logic clk,
  // Port controls
  input wire logic dir,
  input wire logic port_bit,
  // Timer side
  input wire logic wave,
  input wire logic ovr,
  // Pin level
  output logic pin
);
  logic float_q = 1'b0;
  always_ff @(posedge clk) float_q <= ~float_q;
  assign pin = dir ? (ovr ? wave : port_bit) : float_q;
endmodule
`default_nettype wire

// file: test/tb.sv
// Purpose: register-driven tests of the waveform timer
// Assumes: 10 MHz clock, reads sampled just after the data edge
// Notes: counter bursts read one value per cycle
`timescale 1ns/1ns
`default_nettype none
module tb;
  import tmr_wave_pkg::*;
  logic clk_sys, rst, wr, rd, wave_a, wave_b, ovr_a, ovr_b;
  logic pin_dir, pin_data, pin_a, w;
  logic [3:0] addr;
  logic [15:0] wdata, rdata, hi, top;
  logic [15:0] rb [0:299];
  logic [2:0] mode;
  logic [2:0] modes [4] = '{WM_FAST_FF, WM_FAST_A, WM_PCPWM_FF, WM_PCPWM_A};
  logic [2:0] pcs [4] = '{CS_8, CS_64, CS_256, CS_1024};
  int pdiv [4] = '{8, 64, 256, 1024};
  int errors, total_checks, bad;
  tmr_wave dut (.CLK_SYS(clk_sys), .RST(rst), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .WAVE_OUT_A(wave_a),
    .WAVE_OUT_B(wave_b), .OVR_A(ovr_a), .OVR_B(ovr_b));
  port_pin_model pin_i (.clk(clk_sys), .dir(pin_dir), .port_bit(pin_data),
    .wave(wave_a), .ovr(ovr_a), .pin(pin_a));
  function automatic logic [15:0] cfg(input logic [2:0] m,
    input logic [2:0] cs, input logic [1:0] cb, input logic [1:0] ca);
    return {6'h00, ca, cb, cs, m};
  endfunction
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  task automatic rd_burst(input logic [3:0] a, input int n);
    @(posedge clk_sys);
    rd <= 1'b1;
    addr <= a;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      if (i == n - 1) rd <= 1'b0;
      #1 rb[i] = rdata;
    end
  endtask
  task automatic chk(input string nm, input logic [15:0] e,
    input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    #4_000_000;
    errors++;
    $display("watchdog expired");
    report_and_stop();
  end
  initial begin
    {rst, wr, rd, pin_dir, pin_data} = 5'b10000;
    addr = '0;
    wdata = '0;
    errors = 0;
    total_checks = 0;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    wr_reg(4'hF, 16'hFFFF);
    for (int a = 0; a < 6; a++) begin
      rd_burst((a == 5) ? 4'hF : a[3:0], 1);
      chk("reset value", 16'h0000, rb[0]);
    end
    $display("test reset done");
    for (int m = 0; m < 4; m++) begin
      mode = modes[m];
      top = (mode == WM_FAST_FF || mode == WM_PCPWM_FF) ? 16'h00FF : 16'h0009;
      wr_reg(A_CTRL, cfg(WM_CTC, CS_STOP, COM_OFF, COM_OFF));
      wr_reg(A_CMPA, 16'h0009);
      wr_reg(A_CMPB, 16'h00FF);
      wr_reg(A_CNT, 16'h0000);
      wr_reg(A_FLAGS, 16'h0007);
      wr_reg(A_CTRL, cfg(mode, CS_1, COM_CLR, COM_OFF));
      rd_burst(A_CNT, 300);
      hi = 16'h0000;
      bad = 0;
      for (int i = 0; i < 299; i++) begin
        if (rb[i] > hi) hi = rb[i];
        if (mode[1] && rb[i+1] !== ((rb[i] == top) ? 16'h0 : rb[i] + 1)) bad++;
        if (!mode[1] && rb[i+1] != rb[i] + 1 && rb[i+1] != rb[i] - 1) bad++;
      end
      chk("pwm top", top, hi);
      chk("pwm steps", 16'h0000, bad[15:0]);
      repeat (600) @(posedge clk_sys);
      rd_burst(A_FLAGS, 1);
      chk("pwm overflow", 16'h0001, rb[0] & 16'h0001);
    end
    $display("test pwm modes done");
    wr_reg(A_CTRL, cfg(WM_CTC, CS_STOP, COM_OFF, COM_OFF));
    wr_reg(A_CMPA, 16'h0003);
    wr_reg(A_CNT, 16'h0000);
    wr_reg(A_FLAGS, 16'h0007);
    wr_reg(A_CTRL, cfg(WM_CTC, CS_1, COM_OFF, COM_OFF));
    rd_burst(A_CNT, 40);
    hi = 16'h0000;
    for (int i = 0; i < 40; i++) if (rb[i] > hi) hi = rb[i];
    chk("ctc top", 16'h0003, hi);
    rd_burst(A_FLAGS, 1);
    chk("ctc flags", 16'h0002, rb[0] & 16'h0003);
    wr_reg(A_CTRL, cfg(WM_CTC, CS_STOP, COM_OFF, COM_OFF));
    wr_reg(A_CNT, 16'h0010);
    wr_reg(A_CMPA, 16'h0005);
    wr_reg(A_FLAGS, 16'h0007);
    wr_reg(A_CTRL, cfg(WM_CTC, CS_1, COM_OFF, COM_OFF));
    repeat (100) @(posedge clk_sys);
    rd_burst(A_FLAGS, 1);
    chk("missed match", 16'h0000, rb[0] & 16'h0003);
    repeat (200) @(posedge clk_sys);
    rd_burst(A_FLAGS, 1);
    chk("after wrap", 16'h0003, rb[0] & 16'h0003);
    wr_reg(A_CTRL, cfg(WM_CTC, CS_STOP, COM_OFF, COM_OFF));
    wr_reg(A_FLAGS, 16'h0007);
    rd_burst(A_FLAGS, 1);
    chk("flag clear", 16'h0000, rb[0]);
    wr_reg(A_CMPA, 16'h0020);
    wr_reg(A_CNT, 16'h0020);
    wr_reg(A_CTRL, cfg(WM_CTC, CS_1, COM_OFF, COM_OFF));
    repeat (10) @(posedge clk_sys);
    rd_burst(A_FLAGS, 1);
    chk("blocked match", 16'h0000, rb[0] & 16'h0002);
    $display("test clear on match done");
    wr_reg(A_CMPA, 16'h0000);
    wr_reg(A_CTRL, cfg(WM_CTC, CS_1, COM_OFF, COM_TOG));
    repeat (700) @(posedge clk_sys);
    pin_dir <= 1'b1;
    #1 w = wave_a;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      #1 chk("square wave", {15'h0, ~w}, {15'h0, wave_a});
      w = wave_a;
      chk("pin level", {15'h0, wave_a}, {15'h0, pin_a});
    end
    chk("override", 16'h0001, {15'h0, ovr_a});
    wr_reg(A_CTRL, cfg(WM_CTC, CS_1, COM_OFF, COM_OFF));
    #1 w = wave_a;
    repeat (20) @(posedge clk_sys);
    #1 chk("no action", {15'h0, w}, {15'h0, wave_a});
    $display("test outputs done");
    for (int k = 0; k < 4; k++) begin
      wr_reg(A_CTRL, cfg(3'd0, CS_STOP, COM_OFF, COM_OFF));
      wr_reg(A_CNT, 16'h0000);
      wr_reg(A_CTRL, cfg(3'd0, pcs[k], COM_OFF, COM_OFF));
      repeat (10 * pdiv[k]) @(posedge clk_sys);
      rd_burst(A_CNT, 1);
      chk("prescale", 16'h0001, {15'h0, rb[0] >= 9 && rb[0] <= 11});
    end
    $display("test prescale done");
    report_and_stop();
  end
endmodule
`default_nettype wire

// file: test/tmr_wave_props.sv
// Purpose: port-level checks for the waveform timer
// Assumes: steady-state checks only with prescale 1
// Notes: shadows control and compare writes
`timescale 1ns/1ns
`default_nettype none
module tmr_wave_props (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // Register port
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [15:0] RDATA,
  // Waveform outputs
  input wire logic WAVE_OUT_A,
  input wire logic WAVE_OUT_B,
  input wire logic OVR_A,
  input wire logic OVR_B
);
  import tmr_wave_pkg::*;
  logic [9:0] ctl_q;
  logic [7:0] cmpa_q;
  logic [7:0] cmpb_q;
  logic [9:0] quiet_q;
  logic steady;
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ctl_q <= '0;
      cmpa_q <= '0;
      cmpb_q <= '0;
    end else if (WR) begin
      if (ADDR == A_CTRL) ctl_q <= WDATA[9:0];
      if (ADDR == A_CMPA) cmpa_q <= WDATA[7:0];
      if (ADDR == A_CMPB) cmpb_q <= WDATA[7:0];
    end
  end
  // Cycles since the last write
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) quiet_q <= '0;
    else if (WR) quiet_q <= '0;
    else if (quiet_q < 10'd1000) quiet_q <= quiet_q + 10'd1;
  end
  assign steady = (quiet_q >= 10'd600) && (ctl_q[5:3] == CS_1);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  AST_RD_IDLE: assert property (
    !$past(RD) |-> RDATA == 16'h0000) else $error("read data not zero");
  AST_RD_UPPER: assert property (
    $past(RD) && $past(ADDR) != A_CTRL |-> RDATA[15:8] == 8'h00)
    else $error("upper read bits set");
  AST_UNMAPPED: assert property (
    $past(RD) && $past(ADDR) > A_FLAGS |-> RDATA == 16'h0000)
    else $error("unmapped read not zero");
  AST_OVR_A: assert property (
    OVR_A == (ctl_q[9:8] != COM_OFF)) else $error("override A wrong");
  AST_OVR_B: assert property (
    OVR_B == (ctl_q[7:6] != COM_OFF)) else $error("override B wrong");
  AST_OFF_A: assert property (
    ctl_q[9:8] == COM_OFF && $past(ctl_q[9:8]) == COM_OFF
    |-> $stable(WAVE_OUT_A)) else $error("wave A moved while off");
  AST_OFF_B: assert property (
    ctl_q[7:6] == COM_OFF && $past(ctl_q[7:6]) == COM_OFF
    |-> $stable(WAVE_OUT_B)) else $error("wave B moved while off");
  AST_CTC_TOG: assert property (
    steady && ctl_q[2:0] == WM_CTC && ctl_q[9:8] == COM_TOG
    && cmpa_q == 8'h00 |-> WAVE_OUT_A != $past(WAVE_OUT_A))
    else $error("square wave A missed a toggle");
  AST_FAST_MAX: assert property (
    steady && ctl_q[2:0] == WM_FAST_FF && ctl_q[7:6] == COM_CLR
    && cmpb_q == MAXV |-> WAVE_OUT_B) else $error("wave B not held high");
endmodule
bind tmr_wave tmr_wave_props chk_i (.CLK_SYS(CLK_SYS), .RST(RST),
  .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .WAVE_OUT_A(WAVE_OUT_A), .WAVE_OUT_B(WAVE_OUT_B),
  .OVR_A(OVR_A), .OVR_B(OVR_B));
`default_nettype wire
